// File: bench/cpmc_assertions.sv
`timescale 1ns/1ps
// ====================
// Port checks; the pin output enable marks pin control mode.
module cpmc_checker (
    input wire logic clock_i, nrst_i, power_on_reset_n_i, serial_data_o,
    input wire logic interface_select_pin_o, interface_select_pin_oe_o,
    input wire logic [3:0] route_pins_i,
    input wire cpmc_pkg::cpmc_spdif_status_t spdif_status_i,
    input wire cpmc_pkg::cpmc_power_t power_o,
    input wire cpmc_pkg::cpmc_route_t route_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire hw = interface_select_pin_oe_o;
    sequence held; (hw && $stable(route_pins_i))[*6]; endsequence
    a_master_override: assert property (power_o.outputs_mute |-> !power_o.ref_on && !power_o.adc_on
        && power_o.dac_on == 3'h0 && !power_o.rx_on) else $error("master off left a block on");
    a_por_defaults: assert property (!power_on_reset_n_i [*5] |-> !power_o.adc_on && !power_o.pll_a_on
        && power_o.osc_out_on && power_o.ref_low_z) else $error("defaults lost while not ready");
    a_hw_defaults: assert property (hw [*3] |-> !power_o.adc_on && power_o.dac_on == 3'h0)
        else $error("pin mode left blocks powered");
    a_hw_no_secondary: assert property (hw [*3] |-> !route_o.secondary_audio_port_on)
        else $error("secondary port active in pin mode");
    a_hw_unlock_pin: assert property (hw && $past(hw) |->
        interface_select_pin_o == $past(spdif_status_i.unlock)) else $error("unlock pin wrong");
    a_hw_nonaudio_pin: assert property (hw && $past(hw) |-> serial_data_o ==
        $past(spdif_status_i.pcm_n | spdif_status_i.audio_n)) else $error("non-audio pin wrong");
    a_hw_dac_ptx: assert property (held |-> route_o.dac_source_sel == {2{route_pins_i[0]}}
        && route_o.primary_tx_source_sel == {1'h0, route_pins_i[1]}) else $error("route pins 1 2 ignored");
    a_hw_spdif_src: assert property (held |-> route_o.spdif_out_source_sel ==
        (route_pins_i[3:2] == 2'h2 ? 2'h0 : route_pins_i[3:2])) else $error("route pins 3 4 ignored");
    c_hw_primary: cover property (hw ##1 route_o.spdif_out_source_sel == 2'h3);
    c_mute: cover property (power_o.outputs_mute);
    c_dac_mix: cover property (power_o.dac_on == 3'h5);
endmodule
bind cpmc_power_mode_ctrl cpmc_checker i_chk (.*);

// File: bench/cpmc_host_model.sv
`timescale 1ns/1ps
// ====================
// Host on the 3-wire port; sclk rests low between frames and each phase lasts 5 clocks.
module cpmc_host_model (
    input  wire logic clock_i,
    input  wire logic sdo_i,
    output logic      csb_n_o,
    output logic      sclk_o,
    output logic      sdin_o
);
    initial {csb_n_o, sclk_o, sdin_o} = 3'h4;
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        csb_n_o <= 1'h0;
        for (int i = 15; i >= 0; i--) begin
            sdin_o <= w[i];
            repeat (5) @(posedge clock_i);
            sclk_o <= 1'h1;
            r[i] = sdo_i;
            repeat (5) @(posedge clock_i);
            sclk_o <= 1'h0;
        end
        repeat (4) @(posedge clock_i);
        csb_n_o <= 1'h1;
        sdin_o <= ~sdin_o; // A released line must not keep the last bit.
        repeat (7) @(posedge clock_i);
    endtask
endmodule

// File: bench/cpmc_power_mode_ctrl_bench.sv
`timescale 1ns/1ps
// ====================
// Rows are {address, data, expected power word}; each frame also reads back the previous row.
module cpmc_power_mode_ctrl_bench;
    logic clock_i = 1'h0, nrst_i = 1'h0, por_n = 1'h0, strap = 1'h0, csb_n, sclk, sdin, sdo, sdo_oe, isp_o, isp_oe;
    logic [3:0] pins = 4'h0;
    logic [15:0] r;
    cpmc_pkg::cpmc_spdif_status_t st = 3'h0;
    cpmc_pkg::cpmc_power_t pwr;
    cpmc_pkg::cpmc_route_t rt;
    int n_fail = 0, compares = 0, cyc = 0;
    logic [28:0] rows [8] = '{{7'h33, 9'h000, 13'h107F}, {7'h32, 9'h008, 13'h16FF}, {7'h32, 9'h048, 13'h147F},
        {7'h1D, 9'h000, 13'h147E}, {7'h33, 9'h03F, 13'h1400}, {7'h32, 9'h05E, 13'h1000},
        {7'h32, 9'h05F, 13'h0800}, {7'h32, 9'h001, 13'h0800}};
    initial forever #25 clock_i = ~clock_i;
    // A released readback line shows the inverse, so a missing output enable corrupts the word.
    cpmc_host_model i_host (.clock_i(clock_i), .sdo_i(sdo_oe ? sdo : ~sdo),
        .csb_n_o(csb_n), .sclk_o(sclk), .sdin_o(sdin));
    cpmc_power_mode_ctrl i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .power_on_reset_n_i(por_n),
        .control_method_strap_i(strap), .ctrl_csb_n_i(csb_n), .ctrl_sclk_i(sclk), .ctrl_sdin_i(sdin),
        .serial_data_o(sdo), .serial_data_oe_o(sdo_oe), .interface_select_pin_i(isp_oe ? isp_o : 1'h1),
        .interface_select_pin_o(isp_o), .interface_select_pin_oe_o(isp_oe), .route_pins_i(pins),
        .spdif_status_i(st), .power_o(pwr), .route_o(rt));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // A hang is cut short well past the few thousand cycles the run needs.
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 15000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(posedge clock_i);
        nrst_i <= 1'h1;
        repeat (2) @(posedge clock_i);
        i_host.xfer({cpmc_pkg::ADDR_PWRDN1, 9'h000}, r);
        por_n <= 1'h1;
        repeat (8) @(posedge clock_i);
        chk({3'h0, pwr}, 16'h1041);
        chk({9'h000, rt}, 16'h0069);
        for (int i = 0; i < 8; i++) begin
            i_host.xfer(rows[i][28:13], r);
            chk({3'h0, pwr}, {3'h0, rows[i][12:0]});
            if (i > 0) chk(r, {7'h00, rows[i-1][21:13]});
        end
        i_host.xfer({cpmc_pkg::ADDR_ID_LOW, 9'h000}, r);
        i_host.xfer({cpmc_pkg::ADDR_MISC_CTRL, 9'h001}, r);
        chk(r, 16'h005A);
        i_host.xfer({cpmc_pkg::ADDR_ID_HIGH, 9'h000}, r);
        i_host.xfer({cpmc_pkg::ADDR_MISC_CTRL, 9'h000}, r);
        chk(r, 16'h0000);
        strap <= 1'h1;
        por_n <= 1'h0;
        repeat (8) @(posedge clock_i);
        por_n <= 1'h1;
        for (int p = 0; p < 16; p++) begin
            pins <= p[3:0];
            st <= p[2:0];
            repeat (9) @(posedge clock_i);
        end
        chk({9'h000, rt}, 16'h006E);
        chk({14'h0000, isp_o, sdo}, 16'h0003);
        test_done();
    end
endmodule

// File: common/cpmc_pkg.sv
package cpmc_pkg;

    // ============================================================
    // Control word layout
    // ============================================================
    localparam int ADDR_W     = 7;
    localparam int DATA_W     = 9;
    localparam int FRAME_BITS = ADDR_W + DATA_W;
    localparam logic [4:0] FRAME_BITS_CNT = 5'h10;

    // ============================================================
    // Register addresses
    // ============================================================
    localparam logic [ADDR_W-1:0] ADDR_ID_LOW    = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_ID_HIGH   = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_REVISION  = 7'h02;
    localparam logic [ADDR_W-1:0] ADDR_DAC_ROUTE = 7'h0C;
    localparam logic [ADDR_W-1:0] ADDR_PTX_ROUTE = 7'h0D;
    localparam logic [ADDR_W-1:0] ADDR_ADC_CTRL1 = 7'h1D;
    localparam logic [ADDR_W-1:0] ADDR_PWRDN1    = 7'h32;
    localparam logic [ADDR_W-1:0] ADDR_PWRDN2    = 7'h33;
    localparam logic [ADDR_W-1:0] ADDR_MISC_CTRL = 7'h3A;

    // ============================================================
    // Field positions
    // ============================================================
    localparam int PD1_MASTER_BIT   = 0;
    localparam int PD1_ADC_BIT      = 1;
    localparam int PD1_DAC_LSB      = 2;
    localparam int PD1_ALL_DAC_BIT  = 6;
    localparam int PD2_OSC_BIT      = 0;
    localparam int PD2_PLL_A_BIT    = 1;
    localparam int PD2_PLL_B_BIT    = 2;
    localparam int PD2_RECOVERY_BIT = 3;
    localparam int PD2_TX_BIT       = 4;
    localparam int PD2_RX_BIT       = 5;
    localparam int ADC1_REF_SEL_BIT = 8;
    localparam int ROUTE_SRC_LSB    = 7;
    localparam int MISC_CONTINUOUS_READBACK_BIT = 0;
    localparam int MISC_SPDIF_OUT_SOURCE_SEL_LSB   = 1;

    // ============================================================
    // Values after reset
    // ============================================================
    localparam logic [DATA_W-1:0] PWRDN1_RST    = 9'h05E;
    localparam logic [DATA_W-1:0] PWRDN2_RST    = 9'h03E;
    localparam logic [DATA_W-1:0] ADC_CTRL1_RST = 9'h100;
    localparam logic [DATA_W-1:0] DAC_ROUTE_RST = 9'h18A;
    localparam logic [DATA_W-1:0] PTX_ROUTE_RST = 9'h08A;
    localparam logic [DATA_W-1:0] MISC_CTRL_RST = 9'h000;

    // ============================================================
    // Source selection codes
    // ============================================================
    localparam logic [1:0] SRC_SPDIF_RX = 2'h0;
    localparam logic [1:0] SRC_ADC      = 2'h1;
    localparam logic [1:0] SRC_PRIMARY_AUDIO_PORT_RX  = 2'h3;

    // ============================================================
    // Types
    // ============================================================
    typedef enum logic [1:0] {
        CPMC_PORT_IDLE,
        CPMC_PORT_SHIFT,
        CPMC_PORT_DONE
    } cpmc_port_state_t;

    typedef struct packed {
        logic       ref_on;
        logic       outputs_mute;
        logic       adc_on;
        logic [2:0] dac_on;
        logic       osc_out_on;
        logic       pll_a_on;
        logic       pll_b_on;
        logic       recovery_on;
        logic       tx_on;
        logic       rx_on;
        logic       ref_low_z;
    } cpmc_power_t;

    typedef struct packed {
        logic [1:0] dac_source_sel;
        logic [1:0] primary_tx_source_sel;
        logic [1:0] spdif_out_source_sel;
        logic       secondary_audio_port_on;
    } cpmc_route_t;

    typedef struct packed {
        logic unlock;
        logic pcm_n;
        logic audio_n;
    } cpmc_spdif_status_t;

endpackage

// File: hdl/cpmc_power_mode_ctrl.sv
`timescale 1ns/1ps
// Function
// RL1: Master power-off bit shuts everything down, mutes outputs, overrides other bits.
// RL2: ADC power-off bit one disables ADC; zero enables it.
// RL3: Per-DAC field bits 4:2, reset 111, disables DAC1..DAC3 individually.
// RL4: All-DAC bit 6 disables every DAC; when zero the per-DAC field governs.
// RL5: Second register bit 0 disables oscillator output when one.
// RL6: Bits 1 and 2 power down PLL A and PLL B respectively.
// RL7: Bit 3 powers down S/PDIF clock recovery.
// RL8: Bit 4 powers down the S/PDIF transmitter.
// RL9: Bit 5 powers down the S/PDIF receiver.
// RL10: After reset all powerdown bits are one except oscillator and master.
// RL11: Host should power down ADC and DACs before setting master power-off.
// RL12: Writes before power-on reset release are ignored; registers then hold defaults.
// RL13: ADC control bit 8 selects low (one, default) or high reference impedance.
// RL14: Reads of addresses 0 and 1 return identity bytes; 2 returns revision.
// RL15: Identity bytes are not returned while continuous readback is one.
// RL16: Strap low selects register control, high selects pin control.
// RL17: Pin mode uses defaults for pinless features; software mode uses routing fields.
// RL18: Pin mode: route pins 1 and 2 select DAC and primary transmit source.
// RL19: Pin mode: route pins 4,3 select S/PDIF transmit source; 1,0 unavailable.
// RL20: Secondary audio port is inactive whenever pin mode is selected.
// RL21: Pin mode: interface-select pin outputs the unlock flag.
// RL22: Pin mode: serial data output drives OR of non-audio code and status bit.
// RL23: Register changes reach sub-blocks the cycle after the write completes.
module cpmc_power_mode_ctrl #(
    parameter logic [7:0] ID_LOW_VALUE   = 8'h5A, // Arbitrary identity value.
    parameter logic [7:0] ID_HIGH_VALUE  = 8'hA5, // Arbitrary identity value.
    parameter logic [7:0] REVISION_VALUE = 8'h01  // Arbitrary revision value.
) (
    input  wire logic                        clock_i,
    input  wire logic                        nrst_i,
    input  wire logic                        power_on_reset_n_i,
    input  wire logic                        control_method_strap_i,
    input  wire logic                        ctrl_csb_n_i,
    input  wire logic                        ctrl_sclk_i,
    input  wire logic                        ctrl_sdin_i,
    output logic                             serial_data_o,
    output logic                             serial_data_oe_o,
    input  wire logic                        interface_select_pin_i,
    output logic                             interface_select_pin_o,
    output logic                             interface_select_pin_oe_o,
    input  wire logic [3:0]                  route_pins_i,
    input  wire cpmc_pkg::cpmc_spdif_status_t spdif_status_i,
    output cpmc_pkg::cpmc_power_t            power_o,
    output cpmc_pkg::cpmc_route_t            route_o
);

    // ============================================================
    // Pin synchronisers
    // ============================================================
    localparam int SYNC_W = 10;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_meta_reg;
    logic [SYNC_W-1:0] pins_sync_reg;
    logic              csb_dly_reg;
    logic              sclk_dly_reg;

    assign pins_raw = {route_pins_i, interface_select_pin_i, power_on_reset_n_i,
                       control_method_strap_i, ctrl_sdin_i, ctrl_sclk_i, ctrl_csb_n_i};

    // Every pin passes two flops; only the second stage is read by logic.
    // The select bit resets high, its idle level, so no false frame edge follows reset.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pins_meta_reg <= {{(SYNC_W-1){1'b0}}, 1'b1};
            pins_sync_reg <= {{(SYNC_W-1){1'b0}}, 1'b1};
        end else begin
            pins_meta_reg <= pins_raw;
            pins_sync_reg <= pins_meta_reg;
        end
    end

    logic       csb_n;
    logic       sclk;
    logic       sdin;
    logic       strap;
    logic       por_ready;
    logic       three_wire_sel;
    logic [3:0] route_pins;

    assign csb_n          = pins_sync_reg[0];
    assign sclk           = pins_sync_reg[1];
    assign sdin           = pins_sync_reg[2];
    assign strap          = pins_sync_reg[3];
    assign por_ready      = pins_sync_reg[4];
    assign three_wire_sel = pins_sync_reg[5];
    assign route_pins     = pins_sync_reg[9:6];

    // Delayed copies give clean edge detection on the synchronised lines.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            csb_dly_reg  <= 1'b1;
            sclk_dly_reg <= 1'b0;
        end else begin
            csb_dly_reg  <= csb_n;
            sclk_dly_reg <= sclk;
        end
    end

    logic frame_start;
    logic frame_end;
    logic sclk_rise;
    logic sclk_fall;

    assign frame_start = csb_dly_reg && !csb_n;
    assign frame_end   = !csb_dly_reg && csb_n;
    assign sclk_rise   = !sclk_dly_reg && sclk;
    assign sclk_fall   = sclk_dly_reg && !sclk;

    // ============================================================
    // Control method strap
    // ============================================================
    logic hw_mode_reg;

    // The strap follows the pin while power-on reset holds and is frozen at release,
    // so a glitch on the pin later cannot flip the control method mid-operation.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hw_mode_reg <= 1'b0;
        end else if (!por_ready) begin
            hw_mode_reg <= strap; // RL16
        end
    end

    // ============================================================
    // Serial control port
    // ============================================================
    cpmc_pkg::cpmc_port_state_t port_state_reg;
    logic [cpmc_pkg::FRAME_BITS-1:0] in_shift_reg;
    logic [4:0]                      bit_cnt_reg;
    logic                            write_pulse;

    // Frames are only recognised in register control with the 3-wire port selected.
    logic port_enabled;
    assign port_enabled = por_ready && !hw_mode_reg && three_wire_sel; // RL12

    // Port sequencing: a frame opens on select falling and closes on select rising.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_state_reg <= cpmc_pkg::CPMC_PORT_IDLE;
        end else if (!port_enabled) begin
            port_state_reg <= cpmc_pkg::CPMC_PORT_IDLE; // RL12
        end else begin
            unique case (port_state_reg)
                cpmc_pkg::CPMC_PORT_IDLE: begin
                    if (frame_start) begin
                        port_state_reg <= cpmc_pkg::CPMC_PORT_SHIFT;
                    end
                end
                cpmc_pkg::CPMC_PORT_SHIFT: begin
                    if (frame_end) begin
                        port_state_reg <= cpmc_pkg::CPMC_PORT_DONE;
                    end
                end
                cpmc_pkg::CPMC_PORT_DONE: begin
                    port_state_reg <= cpmc_pkg::CPMC_PORT_IDLE;
                end
            endcase
        end
    end

    // Bits are taken on each rising serial clock, MSB (address) first.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_shift_reg <= '0;
            bit_cnt_reg  <= '0;
        end else if (frame_start) begin
            in_shift_reg <= '0;
            bit_cnt_reg  <= '0;
        end else if (port_state_reg == cpmc_pkg::CPMC_PORT_SHIFT && sclk_rise) begin
            in_shift_reg <= {in_shift_reg[cpmc_pkg::FRAME_BITS-2:0], sdin};
            if (bit_cnt_reg != 5'h1F) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // A frame with any count other than sixteen bits is dropped whole.
    assign write_pulse = (port_state_reg == cpmc_pkg::CPMC_PORT_DONE) &&
                         (bit_cnt_reg == cpmc_pkg::FRAME_BITS_CNT) && port_enabled;

    logic [cpmc_pkg::ADDR_W-1:0] wr_addr;
    logic [cpmc_pkg::DATA_W-1:0] wr_data;

    assign wr_addr = in_shift_reg[cpmc_pkg::FRAME_BITS-1:cpmc_pkg::DATA_W];
    assign wr_data = in_shift_reg[cpmc_pkg::DATA_W-1:0];

    // ============================================================
    // Register file
    // ============================================================
    logic [cpmc_pkg::DATA_W-1:0] pwrdn1_reg;
    logic [cpmc_pkg::DATA_W-1:0] pwrdn2_reg;
    logic [cpmc_pkg::DATA_W-1:0] adc_ctrl1_reg;
    logic [cpmc_pkg::DATA_W-1:0] dac_route_reg;
    logic [cpmc_pkg::DATA_W-1:0] ptx_route_reg;
    logic [cpmc_pkg::DATA_W-1:0] misc_ctrl_reg;
    logic [cpmc_pkg::ADDR_W-1:0] read_ptr_reg;

    // Registers sit at defaults until power-on reset releases; writes then land.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwrdn1_reg    <= cpmc_pkg::PWRDN1_RST; // RL10
            pwrdn2_reg    <= cpmc_pkg::PWRDN2_RST; // RL10
            adc_ctrl1_reg <= cpmc_pkg::ADC_CTRL1_RST;
            dac_route_reg <= cpmc_pkg::DAC_ROUTE_RST;
            ptx_route_reg <= cpmc_pkg::PTX_ROUTE_RST;
            misc_ctrl_reg <= cpmc_pkg::MISC_CTRL_RST;
        end else if (!por_ready) begin
            pwrdn1_reg    <= cpmc_pkg::PWRDN1_RST; // RL12
            pwrdn2_reg    <= cpmc_pkg::PWRDN2_RST;
            adc_ctrl1_reg <= cpmc_pkg::ADC_CTRL1_RST;
            dac_route_reg <= cpmc_pkg::DAC_ROUTE_RST;
            ptx_route_reg <= cpmc_pkg::PTX_ROUTE_RST;
            misc_ctrl_reg <= cpmc_pkg::MISC_CTRL_RST;
        end else if (write_pulse) begin
            unique case (wr_addr)
                cpmc_pkg::ADDR_PWRDN1:    pwrdn1_reg    <= wr_data;
                cpmc_pkg::ADDR_PWRDN2:    pwrdn2_reg    <= wr_data;
                cpmc_pkg::ADDR_ADC_CTRL1: adc_ctrl1_reg <= wr_data;
                cpmc_pkg::ADDR_DAC_ROUTE: dac_route_reg <= wr_data;
                cpmc_pkg::ADDR_PTX_ROUTE: ptx_route_reg <= wr_data;
                cpmc_pkg::ADDR_MISC_CTRL: misc_ctrl_reg <= wr_data;
                default: ; // Other addresses are read-only here (identity, revision) or belong to blocks outside this one.
            endcase
        end
    end

    // The address of the last accepted frame is the one read back next.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            read_ptr_reg <= '0;
        end else if (!por_ready) begin
            read_ptr_reg <= '0;
        end else if (write_pulse) begin
            read_ptr_reg <= wr_addr;
        end
    end

    // ============================================================
    // Readback
    // ============================================================
    logic                        cont_read;
    logic [cpmc_pkg::DATA_W-1:0] rd_data;

    assign cont_read = misc_ctrl_reg[cpmc_pkg::MISC_CONTINUOUS_READBACK_BIT];

    // Identity bytes vanish in continuous readback; unheld addresses read zero.
    always_comb begin
        rd_data = '0;
        unique case (read_ptr_reg)
            cpmc_pkg::ADDR_ID_LOW:    rd_data = cont_read ? '0 : {1'b0, ID_LOW_VALUE};   // RL14 RL15
            cpmc_pkg::ADDR_ID_HIGH:   rd_data = cont_read ? '0 : {1'b0, ID_HIGH_VALUE};  // RL14 RL15
            cpmc_pkg::ADDR_REVISION:  rd_data = cont_read ? '0 : {1'b0, REVISION_VALUE}; // RL14 RL15
            cpmc_pkg::ADDR_PWRDN1:    rd_data = pwrdn1_reg;
            cpmc_pkg::ADDR_PWRDN2:    rd_data = pwrdn2_reg;
            cpmc_pkg::ADDR_ADC_CTRL1: rd_data = adc_ctrl1_reg;
            cpmc_pkg::ADDR_DAC_ROUTE: rd_data = dac_route_reg;
            cpmc_pkg::ADDR_PTX_ROUTE: rd_data = ptx_route_reg;
            cpmc_pkg::ADDR_MISC_CTRL: rd_data = misc_ctrl_reg;
            default:                  rd_data = '0;
        endcase
    end

    logic [cpmc_pkg::FRAME_BITS-1:0] out_shift_reg;

    // The word is loaded as the frame opens and advanced on each falling serial clock,
    // so the host can sample it on the following rising edge.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_shift_reg <= '0;
        end else if (frame_start) begin
            out_shift_reg <= {{cpmc_pkg::ADDR_W{1'b0}}, rd_data};
        end else if (port_state_reg == cpmc_pkg::CPMC_PORT_SHIFT && sclk_fall) begin
            out_shift_reg <= {out_shift_reg[cpmc_pkg::FRAME_BITS-2:0], 1'b0};
        end
    end

    // ============================================================
    // Effective settings
    // ============================================================
    logic [cpmc_pkg::DATA_W-1:0] eff_pd1;
    logic [cpmc_pkg::DATA_W-1:0] eff_pd2;
    logic [cpmc_pkg::DATA_W-1:0] eff_adc1;

    // Pin mode offers no pins for these, so their defaults stand in.
    assign eff_pd1  = hw_mode_reg ? cpmc_pkg::PWRDN1_RST    : pwrdn1_reg;    // RL17
    assign eff_pd2  = hw_mode_reg ? cpmc_pkg::PWRDN2_RST    : pwrdn2_reg;    // RL17
    assign eff_adc1 = hw_mode_reg ? cpmc_pkg::ADC_CTRL1_RST : adc_ctrl1_reg; // RL17

    logic       master_off;
    logic [2:0] dac_off;

    assign master_off = eff_pd1[cpmc_pkg::PD1_MASTER_BIT];
    // The all-DAC bit beats the per-DAC field.
    assign dac_off = eff_pd1[cpmc_pkg::PD1_ALL_DAC_BIT] ? 3'h7 :                // RL4
                     eff_pd1[cpmc_pkg::PD1_DAC_LSB +: 3];                        // RL3

    // ============================================================
    // Power outputs
    // ============================================================
    // Registered one cycle behind the register file, which gives the defined
    // one-cycle latency after a write and keeps outputs glitch free.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            power_o <= '{ref_on: 1'b1, outputs_mute: 1'b0, adc_on: 1'b0, dac_on: 3'h0,
                         osc_out_on: 1'b1, pll_a_on: 1'b0, pll_b_on: 1'b0,
                         recovery_on: 1'b0, tx_on: 1'b0, rx_on: 1'b0, ref_low_z: 1'b1};
        end else begin
            power_o.ref_on       <= !master_off;                                           // RL1 RL23
            power_o.outputs_mute <= master_off;                                            // RL1
            power_o.adc_on       <= !master_off && !eff_pd1[cpmc_pkg::PD1_ADC_BIT];        // RL1 RL2
            power_o.dac_on       <= master_off ? 3'h0 : ~dac_off;                          // RL1 RL3 RL4
            power_o.osc_out_on   <= !master_off && !eff_pd2[cpmc_pkg::PD2_OSC_BIT];        // RL5
            power_o.pll_a_on     <= !master_off && !eff_pd2[cpmc_pkg::PD2_PLL_A_BIT];      // RL6
            power_o.pll_b_on     <= !master_off && !eff_pd2[cpmc_pkg::PD2_PLL_B_BIT];      // RL6
            power_o.recovery_on  <= !master_off && !eff_pd2[cpmc_pkg::PD2_RECOVERY_BIT];   // RL7
            power_o.tx_on        <= !master_off && !eff_pd2[cpmc_pkg::PD2_TX_BIT];         // RL8
            power_o.rx_on        <= !master_off && !eff_pd2[cpmc_pkg::PD2_RX_BIT];         // RL9
            power_o.ref_low_z    <= eff_adc1[cpmc_pkg::ADC1_REF_SEL_BIT];                  // RL13
        end
    end

    // ============================================================
    // Routing outputs
    // ============================================================
    logic [1:0] pin_spdif_src;

    // The unavailable pin pair falls back to received S/PDIF data.
    always_comb begin
        pin_spdif_src = cpmc_pkg::SRC_SPDIF_RX;
        unique case (route_pins[3:2])
            2'h0: pin_spdif_src = cpmc_pkg::SRC_SPDIF_RX; // RL19
            2'h1: pin_spdif_src = cpmc_pkg::SRC_ADC;      // RL19
            2'h2: pin_spdif_src = cpmc_pkg::SRC_SPDIF_RX; // RL19
            2'h3: pin_spdif_src = cpmc_pkg::SRC_PRIMARY_AUDIO_PORT_RX;  // RL19
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            route_o <= '{dac_source_sel: cpmc_pkg::DAC_ROUTE_RST[8:7],
                         primary_tx_source_sel: cpmc_pkg::PTX_ROUTE_RST[8:7],
                         spdif_out_source_sel: cpmc_pkg::MISC_CTRL_RST[2:1],
                         secondary_audio_port_on: 1'b0};
        end else if (hw_mode_reg) begin
            route_o.dac_source_sel          <= route_pins[0] ? cpmc_pkg::SRC_PRIMARY_AUDIO_PORT_RX
                                                             : cpmc_pkg::SRC_SPDIF_RX; // RL18
            route_o.primary_tx_source_sel   <= route_pins[1] ? cpmc_pkg::SRC_ADC
                                                             : cpmc_pkg::SRC_SPDIF_RX; // RL18
            route_o.spdif_out_source_sel    <= pin_spdif_src;                          // RL19
            route_o.secondary_audio_port_on <= 1'b0;                                   // RL20
        end else begin
            route_o.dac_source_sel          <= dac_route_reg[cpmc_pkg::ROUTE_SRC_LSB +: 2]; // RL17 RL23
            route_o.primary_tx_source_sel   <= ptx_route_reg[cpmc_pkg::ROUTE_SRC_LSB +: 2]; // RL17 RL23
            route_o.spdif_out_source_sel    <= misc_ctrl_reg[cpmc_pkg::MISC_SPDIF_OUT_SOURCE_SEL_LSB +: 2]; // RL17
            route_o.secondary_audio_port_on <= por_ready && !master_off;
        end
    end

    // ============================================================
    // Status and readback pins
    // ============================================================
    // In pin mode the two control-port pins turn into S/PDIF status outputs.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_data_o             <= 1'b0;
            serial_data_oe_o          <= 1'b0;
            interface_select_pin_o    <= 1'b0;
            interface_select_pin_oe_o <= 1'b0;
        end else if (hw_mode_reg) begin
            serial_data_o             <= spdif_status_i.pcm_n || spdif_status_i.audio_n; // RL22
            serial_data_oe_o          <= 1'b1;
            interface_select_pin_o    <= spdif_status_i.unlock;                          // RL21
            interface_select_pin_oe_o <= 1'b1;
        end else begin
            serial_data_o             <= out_shift_reg[cpmc_pkg::FRAME_BITS-1];
            serial_data_oe_o          <= port_state_reg == cpmc_pkg::CPMC_PORT_SHIFT;
            interface_select_pin_o    <= 1'b0;
            interface_select_pin_oe_o <= 1'b0;
        end
    end

endmodule
